// ===== cpm_monitor.sv
/*
 Pack current protection monitor: sense gain, offset-adjusted current,
 direction debounce, overcurrent and short-circuit qualification,
 fault flags, FET switch-off, AHB-Lite registers and interrupt.
 Assumes a digitised sense level, a conversion stream from the ADC and
 a calibration offset held steady by nonvolatile storage.
*/
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_monitor
   import cpm_pkg::*;
#(
   parameter int DIR_CYC = `CPM_DIR_CYC
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic lowPowerMode,
   input wire cpm_lvl_t senseLevel,
   input wire logic measPhase,
   input wire logic adcValid,
   input wire logic [13:0] adcCode,
   input wire logic [13:0] calOffset,
   output cpm_gain_e ampGain,
   output logic fetEnable,
   output logic dischargeDir,
   output logic chargeDir,
   output logic irq
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [3:0] ctrl_ff;
   logic [11:0] thr_ff;
   logic [11:0] dly_ff [3];
   logic [4:0] flags_ff;
   logic [4:0] mask_ff;
   logic [13:0] curr14_ff;
   logic [11:0] curr12_ff;
   logic wrPend_ff;
   logic [7:0] wrAddr_ff;
   logic [31:0] rdata_ff;
   logic [6:0] usCnt_ff;
   logic [9:0] msCnt_ff;
   logic [9:0] sCnt_ff;
   logic [9:0] minCnt_ff;
   logic [5:0] secCnt_ff;
   logic usTick_ff;
   logic msTick_ff;
   logic sTick_ff;
   logic minTick_ff;
   logic [24:0] disCnt_ff;
   logic [24:0] chgCnt_ff;
   logic disDir_ff;
   logic chgDir_ff;
   cpm_gain_e gain_ff;
   logic fet_ff;
   logic [4:0] nxt_flags;
   logic [25:0] nxt_dis;
   logic [25:0] nxt_chg;
   cpm_dly_if dlyIf [3] ();

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // threshold in 0.1 mV steps; kind 0 discharge oc, 1 charge oc, 2 short
   function automatic logic [12:0] thrLevel(input logic [1:0] kind, input logic [2:0] code);
      logic [12:0] v;
      v = 13'h0000;
      case ({kind, code})
         5'h00: v = 13'h0028;
         5'h01: v = 13'h0050;
         5'h02: v = 13'h00A0;
         5'h03: v = 13'h00F0;
         5'h04: v = 13'h0140;
         5'h05: v = 13'h01E0;
         5'h06: v = 13'h0280;
         5'h07: v = 13'h03C0;
         5'h08: v = 13'h000A;
         5'h09: v = 13'h0014;
         5'h0A: v = 13'h0028;
         5'h0B: v = 13'h003C;
         5'h0C: v = 13'h0050;
         5'h0D: v = 13'h0078;
         5'h0E: v = 13'h00A0;
         5'h0F: v = 13'h00F0;
         5'h10: v = 13'h00A0;
         5'h11: v = 13'h00F0;
         5'h12: v = 13'h0140;
         5'h13: v = 13'h01E0;
         5'h14: v = 13'h0280;
         5'h15: v = 13'h03C0;
         5'h16: v = 13'h0500;
         5'h17: v = 13'h0A00;
         default: v = 13'h0000;
      endcase
      return v;
   endfunction

   // direction debounce: returns {flag, count}
   function automatic logic [25:0] dirStep(input logic seen, input logic flag,
                                           input logic [24:0] cnt);
      logic [25:0] r;
      r = {flag, 25'h0000000};
      if (seen == flag) begin
         r = {flag, 25'h0000000};
      end else if (seen && cnt >= 25'(DIR_CYC)) begin
         r = {1'b1, 25'h0000000};
      end else if (!seen && cnt >= 25'(DIR_CYC - 1)) begin
         r = {1'b0, 25'h0000000};
      end else begin
         r = {flag, cnt + 25'h0000001};
      end
      return r;
   endfunction

   // wrap counter: true on the last count
   function automatic logic atEnd(input logic [9:0] cnt, input logic [9:0] last);
      return cnt == last;
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire logic addrPh = hsel && hready && htrans[1];
   wire logic wrNow = wrPend_ff;
   wire logic [31:0] rdWord =
      (haddr[7:0] == `CPM_OFS_CTRL) ? {28'h0000000, ctrl_ff} :
      (haddr[7:0] == `CPM_OFS_THR) ? {20'h00000, thr_ff} :
      (haddr[7:0] == `CPM_OFS_DDLY) ? {20'h00000, dly_ff[0]} :
      (haddr[7:0] == `CPM_OFS_CDLY) ? {20'h00000, dly_ff[1]} :
      (haddr[7:0] == `CPM_OFS_SDLY) ? {20'h00000, dly_ff[2]} :
      (haddr[7:0] == `CPM_OFS_STAT) ? {25'h0000000, disDir_ff, chgDir_ff, flags_ff} :
      (haddr[7:0] == `CPM_OFS_MASK) ? {27'h0000000, mask_ff} :
      (haddr[7:0] == `CPM_OFS_CURR) ? {4'h0, curr12_ff, 2'h0, curr14_ff} : 32'h00000000;
   wire logic [4:0] w1c = (wrNow && wrAddr_ff == `CPM_OFS_STAT) ? hwdata[4:0] : 5'h00;

   // one wait state only when a read meets the write data phase of the same register,
   // so that the read returns the freshly written value; always OKAY
   assign hreadyout = !(wrNow && hsel && htrans[1] && !hwrite && haddr[7:0] == wrAddr_ff);
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;

   // address phase capture and read data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
         rdata_ff <= 32'h00000000;
      end else begin
         wrPend_ff <= addrPh && hwrite && hsize == 3'h2;
         wrAddr_ff <= haddr[7:0];
         rdata_ff <= (addrPh && !hwrite) ? rdWord : rdata_ff;
      end
   end

   // writable registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= `CPM_RST_CTRL;
         thr_ff <= `CPM_RST_THR;
         dly_ff[0] <= `CPM_RST_DLY;
         dly_ff[1] <= `CPM_RST_DLY;
         dly_ff[2] <= `CPM_RST_DLY;
         mask_ff <= `CPM_RST_MASK;
      end else if (wrNow) begin
         if (wrAddr_ff == `CPM_OFS_CTRL) ctrl_ff <= hwdata[3:0];
         if (wrAddr_ff == `CPM_OFS_THR) thr_ff <= hwdata[11:0] & 12'h777;
         if (wrAddr_ff == `CPM_OFS_DDLY) dly_ff[0] <= hwdata[11:0];
         if (wrAddr_ff == `CPM_OFS_CDLY) dly_ff[1] <= hwdata[11:0];
         if (wrAddr_ff == `CPM_OFS_SDLY) dly_ff[2] <= hwdata[11:0];
         if (wrAddr_ff == `CPM_OFS_MASK) mask_ff <= hwdata[4:0];
      end
   end

   // ----------------------------------------
   // time base
   // ----------------------------------------
   wire logic usEnd = usCnt_ff == 7'(`CPM_US_CYC - 1);
   wire logic msEnd = usEnd && atEnd(msCnt_ff, 10'(`CPM_UNIT_STEP - 1));
   wire logic sEnd = msEnd && atEnd(sCnt_ff, 10'(`CPM_UNIT_STEP - 1));
   wire logic minEnd = sEnd && secCnt_ff == 6'(`CPM_MIN_S - 1);

   // microsecond, millisecond, second and minute ticks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         usCnt_ff <= 7'h00;
         msCnt_ff <= 10'h000;
         sCnt_ff <= 10'h000;
         secCnt_ff <= 6'h00;
         {usTick_ff, msTick_ff, sTick_ff, minTick_ff} <= 4'h0;
      end else begin
         usCnt_ff <= usEnd ? 7'h00 : usCnt_ff + 7'h01;
         msCnt_ff <= msEnd ? 10'h000 : (usEnd ? msCnt_ff + 10'h001 : msCnt_ff);
         sCnt_ff <= sEnd ? 10'h000 : (msEnd ? sCnt_ff + 10'h001 : sCnt_ff);
         secCnt_ff <= minEnd ? 6'h00 : (sEnd ? secCnt_ff + 6'h01 : secCnt_ff);
         {usTick_ff, msTick_ff, sTick_ff, minTick_ff} <= {usEnd, msEnd, sEnd, minEnd};
      end
   end

   // ----------------------------------------
   // comparisons and delay timers
   // ----------------------------------------
   wire logic monOn = !lowPowerMode;
   wire cpm_lvl_t chgLevel = -senseLevel;
   wire logic docCond = monOn && senseLevel > $signed(thrLevel(2'h0, thr_ff[`CPM_THR_DOC +: 3]));
   wire logic cocCond = monOn && chgLevel > $signed(thrLevel(2'h1, thr_ff[`CPM_THR_COC +: 3]));
   wire logic dscCond = monOn && senseLevel > $signed(thrLevel(2'h2, thr_ff[`CPM_THR_DSC +: 3]));
   wire logic [2:0] conds = {dscCond, cocCond, docCond};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_tmr
         assign dlyIf[gi].usTick = usTick_ff;
         assign dlyIf[gi].msTick = msTick_ff;
         assign dlyIf[gi].sTick = sTick_ff;
         assign dlyIf[gi].minTick = minTick_ff;
         assign dlyIf[gi].cond = conds[gi];
         assign dlyIf[gi].setting = dly_ff[gi];
         cpm_delay_timer u_tmr (
            .clk(clk),
            .nrst(nrst),
            .dly(dlyIf[gi].tmr)
         );
      end
   endgenerate

   wire logic docHit = dlyIf[0].expired;
   wire logic cocHit = dlyIf[1].expired;
   wire logic dscHit = dlyIf[2].expired;

   // ----------------------------------------
   // fault flags, FETs and interrupt
   // ----------------------------------------
   // a new fault wins over a clear in the same cycle
   assign nxt_flags[`CPM_ST_DOC] = (flags_ff[`CPM_ST_DOC] && !w1c[`CPM_ST_DOC]) || docHit;
   assign nxt_flags[`CPM_ST_COC] = (flags_ff[`CPM_ST_COC] && !w1c[`CPM_ST_COC]) || cocHit;
   assign nxt_flags[`CPM_ST_DSC] = (flags_ff[`CPM_ST_DSC] && !w1c[`CPM_ST_DSC]) || dscHit;
   assign nxt_flags[`CPM_ST_LD] = (flags_ff[`CPM_ST_LD] && !w1c[`CPM_ST_LD]) || docHit || dscHit;
   assign nxt_flags[`CPM_ST_CH] = (flags_ff[`CPM_ST_CH] && !w1c[`CPM_ST_CH]) || cocHit;

   wire logic ovr = ctrl_ff[`CPM_CTRL_OVR];
   wire logic ocOff = (flags_ff[`CPM_ST_DOC] || flags_ff[`CPM_ST_COC]) && !ovr;
   wire logic hostOff = ovr && !ctrl_ff[`CPM_CTRL_FETON];
   wire logic nxt_fet = !(ocOff || hostOff || flags_ff[`CPM_ST_DSC]);

   // flags and FET drive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_ff <= 5'h00;
         fet_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         fet_ff <= nxt_fet;
      end
   end

   assign fetEnable = fet_ff;
   assign irq = |(flags_ff & mask_ff);

   // ----------------------------------------
   // direction detection
   // ----------------------------------------
   wire logic disSeen = monOn && senseLevel > $signed(`CPM_DIR_LEVEL);
   wire logic chgSeen = monOn && chgLevel > $signed(`CPM_DIR_LEVEL);
   assign nxt_dis = monOn ? dirStep(disSeen, disDir_ff, disCnt_ff) : 26'h0000000;
   assign nxt_chg = monOn ? dirStep(chgSeen, chgDir_ff, chgCnt_ff) : 26'h0000000;

   // debounced direction flags
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {disDir_ff, disCnt_ff} <= 26'h0000000;
         {chgDir_ff, chgCnt_ff} <= 26'h0000000;
      end else begin
         {disDir_ff, disCnt_ff} <= nxt_dis;
         {chgDir_ff, chgCnt_ff} <= nxt_chg;
      end
   end

   assign dischargeDir = disDir_ff;
   assign chargeDir = chgDir_ff;

   // ----------------------------------------
   // gain and measurement
   // ----------------------------------------
   // reading spans 250, 25 or 2.5 mV each way at x5, x50, x500
   wire cpm_gain_e measGain = cpm_gain_e'(ctrl_ff[1:0]);
   wire cpm_gain_e nxt_gain = measPhase ? measGain : CPM_GAIN_X5;
   wire logic [13:0] adjCode = adcCode - calOffset;

   // gain drive and stored results
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gain_ff <= CPM_GAIN_X5;
         curr14_ff <= 14'h0000;
         curr12_ff <= 12'h000;
      end else begin
         gain_ff <= nxt_gain;
         curr14_ff <= adcValid ? adjCode : curr14_ff;
         curr12_ff <= adcValid ? adjCode[13:2] : curr12_ff;
      end
   end

   assign ampGain = gain_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   short_fet_a: assert property (flags_ff[`CPM_ST_DSC] |=> !fetEnable)
      else $error("FETs on during short");
   oc_fet_a: assert property ((flags_ff[`CPM_ST_DOC] || flags_ff[`CPM_ST_COC]) && !ovr
      |=> !fetEnable) else $error("FETs on during overcurrent");
   doc_load_a: assert property (docHit |=> flags_ff[`CPM_ST_DOC] && flags_ff[`CPM_ST_LD])
      else $error("discharge fault not flagged");
   coc_chg_a: assert property (cocHit |=> flags_ff[`CPM_ST_COC] && flags_ff[`CPM_ST_CH])
      else $error("charge fault not flagged");
   dsc_load_a: assert property (dscHit |=> flags_ff[`CPM_ST_DSC] && flags_ff[`CPM_ST_LD])
      else $error("short not flagged");
   lowpower_off_a: assert property (lowPowerMode |-> !docHit && !cocHit && !dscHit
      ##1 !dischargeDir && !chargeDir) else $error("monitor active in low power");
   dir_rise_a: assert property ($rose(dischargeDir) |-> $past(disSeen, 1) && $past(disSeen, 2))
      else $error("direction set too soon");
   offset_a: assert property (adcValid |=> curr14_ff == 14'($past(adcCode) - $past(calOffset)))
      else $error("offset result wrong");
   meas_gain_a: assert property (measPhase |=> ampGain == $past(measGain))
      else $error("measurement gain wrong");
   auto_gain_a: assert property (!measPhase |=> ampGain == CPM_GAIN_X5)
      else $error("detection gain wrong");
endmodule

// ===== cpm_consts.svh
/*
 Constants of the pack current protection monitor: timing, offsets,
 field positions and reset values.
 Assumes a 100 MHz clock and a sense level in 0.1 mV steps.
*/
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CPM_CLK_NS 10
`define CPM_US_NS 1000
`define CPM_US_CYC (`CPM_US_NS / `CPM_CLK_NS)
`define CPM_UNIT_STEP 1000
`define CPM_MIN_S 60
`define CPM_DIR_MS 2
`define CPM_DIR_CYC (`CPM_DIR_MS * `CPM_UNIT_STEP * `CPM_US_CYC)
`define CPM_DLY_LIMIT 11'h400
`define CPM_DIR_LEVEL 13'h0001
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CPM_OFS_CTRL 8'h00
`define CPM_OFS_THR 8'h04
`define CPM_OFS_DDLY 8'h08
`define CPM_OFS_CDLY 8'h0C
`define CPM_OFS_SDLY 8'h10
`define CPM_OFS_STAT 8'h14
`define CPM_OFS_MASK 8'h18
`define CPM_OFS_CURR 8'h1C
// ----------------------------------------
// fields
// ----------------------------------------
`define CPM_CTRL_OVR 2
`define CPM_CTRL_FETON 3
`define CPM_THR_DOC 0
`define CPM_THR_COC 4
`define CPM_THR_DSC 8
`define CPM_ST_DOC 0
`define CPM_ST_COC 1
`define CPM_ST_DSC 2
`define CPM_ST_LD 3
`define CPM_ST_CH 4
`define CPM_ST_CDIR 5
`define CPM_ST_DDIR 6
`define CPM_CURR_LO 16
// ----------------------------------------
// reset values
// ----------------------------------------
`define CPM_RST_CTRL 4'h0
`define CPM_RST_THR 12'h000
`define CPM_RST_DLY 12'h000
`define CPM_RST_MASK 5'h00
`endif

// ===== cpm_pkg.sv
/*
 Types of the pack current protection monitor.
 Assumes nothing of its surroundings.
*/
package cpm_pkg;
   // amplifier gain choices
   typedef enum logic [1:0] {CPM_GAIN_X5, CPM_GAIN_X50, CPM_GAIN_X500, CPM_GAIN_RSV} cpm_gain_e;
   // sense level, signed, 0.1 mV per step, positive leaves the pack
   typedef logic signed [12:0] cpm_lvl_t;
endpackage

// ===== cpm_dly_if.sv
/*
 Carrier between the monitor and one fault delay timer.
 Assumes all signals are in the one clock domain.
*/
`timescale 1ns/1ps
interface cpm_dly_if;
   logic usTick;
   logic msTick;
   logic sTick;
   logic minTick;
   logic cond;
   logic [11:0] setting;
   logic expired;
   modport ctl (output usTick, msTick, sTick, minTick, cond, setting, input expired);
   modport tmr (input usTick, msTick, sTick, minTick, cond, setting, output expired);
endinterface

// ===== cpm_delay_timer.sv
/*
 Fault delay timer: counts scaled units while its condition holds.
 Assumes unit ticks are one-cycle pulses from the monitor.
*/
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_delay_timer
   import cpm_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   cpm_dly_if.tmr dly
);
   logic [10:0] cnt_ff;
   logic [10:0] nxt_cnt;
   wire logic unitTick;

   // ----------------------------------------
   // unit selection and counting
   // ----------------------------------------
   // scale 00 us, 01 ms, 10 s, 11 minutes
   assign unitTick = dly.setting[11] ? (dly.setting[10] ? dly.minTick : dly.sTick)
                                     : (dly.setting[10] ? dly.msTick : dly.usTick);
   // restart whenever the condition drops
   assign nxt_cnt = !dly.cond ? 11'h000 :
                    (unitTick && cnt_ff < `CPM_DLY_LIMIT) ? cnt_ff + 11'h001 : cnt_ff;
   assign dly.expired = dly.cond && (cnt_ff >= {1'b0, dly.setting[9:0]});

   // count register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= 11'h000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   timer_restart_a: assert property (@(posedge clk) disable iff (!nrst)
      !dly.cond |-> !dly.expired ##1 cnt_ff == 11'h000) else $error("timer not restarted");
   timer_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      dly.cond && cnt_ff < {1'b0, dly.setting[9:0]} |-> !dly.expired)
      else $error("timer expired early");
endmodule

// ===== cpm_sense_model.sv
/*
 Sense resistor and power FET model: the pack draws the demanded current
 only while the FETs conduct.
 Assumes fetEnable from the monitor and the bench's demand level.
*/
`timescale 1ns/1ps
module cpm_sense_model
   import cpm_pkg::*;
(
   input wire logic clk,
   input wire cpm_lvl_t demand,
   input wire logic fetEnable,
   output cpm_lvl_t senseLevel
);
   initial senseLevel = 13'h0000;
   // open FETs stop all pack current, so the resistor drops nothing
   always @(posedge clk) begin
      senseLevel <= fetEnable ? demand : 13'h0000;
   end
endmodule

// ===== tb_top.sv
/*
 Self-checking bench of the current protection monitor.
 Assumes the monitor, its package and the sense model are compiled first.
*/
`timescale 1ns/1ps
`include "cpm_consts.svh"
module tb_top
   import cpm_pkg::*;
;
   localparam int DIRC = 20;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, fetEnable, dischargeDir, chargeDir, irq;
   logic lowPowerMode = 1'b0;
   logic measPhase = 1'b0;
   logic adcValid = 1'b0;
   logic [13:0] adcCode = 14'h0;
   logic [13:0] calOffset = 14'h0;
   cpm_lvl_t demand = 13'h0;
   cpm_lvl_t senseLevel;
   cpm_gain_e ampGain;
   int n_mismatch = 0;
   int n_compared = 0;
   int docT[8] = '{40, 80, 160, 240, 320, 480, 640, 960};
   int cocT[8] = '{10, 20, 40, 60, 80, 120, 160, 240};
   int scT[8] = '{160, 240, 320, 480, 640, 960, 1280, 2560};

   // clock of 10 ns
   always #5 clk = ~clk;

   cpm_monitor #(.DIR_CYC(DIRC)) DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lowPowerMode(lowPowerMode),
      .senseLevel(senseLevel), .measPhase(measPhase), .adcValid(adcValid), .adcCode(adcCode),
      .calOffset(calOffset), .ampGain(ampGain), .fetEnable(fetEnable),
      .dischargeDir(dischargeDir), .chargeDir(chargeDir), .irq(irq));

   cpm_sense_model SENSE (.clk(clk), .demand(demand), .fetEnable(fetEnable),
      .senseLevel(senseLevel));

   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one single AHB-Lite word transfer, read data left in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask

   function automatic logic [31:0] thr(input logic [2:0] d, input logic [2:0] c,
      input logic [2:0] s);
      return {21'h0, s, 1'b0, c, 1'b0, d};
   endfunction

   // level at the threshold must not trip, one step past it must
   task automatic trip(input cpm_lvl_t e, input cpm_lvl_t s, input logic [4:0] x);
      demand <= e;
      cyc(6);
      rchk(`CPM_OFS_STAT, 32'h1F, 32'h0);
      demand <= e + s;
      cyc(6);
      rchk(`CPM_OFS_STAT, 32'h1F, {27'h0, x});
      chk(fetEnable, 1'b0);
      chk(irq, 1'b1);
      demand <= 13'h0;
      wr(`CPM_OFS_STAT, 32'h1F);
      cyc(3);
      chk(fetEnable, 1'b1);
      chk(irq, 1'b0);
   endtask

   // conversion result minus offset, both widths
   task automatic conv(input logic [13:0] c, input logic [13:0] o);
      logic [13:0] r;
      r = c - o;
      calOffset <= o;
      adcCode <= c;
      adcValid <= 1'b1;
      cyc(1);
      adcValid <= 1'b0;
      cyc(2);
      rchk(`CPM_OFS_CURR, 32'h0FFF3FFF, {4'h0, r[13:2], 2'h0, r});
   endtask

   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      cyc(4);
      nrst <= 1'b1;
      cyc(2);
      chk(fetEnable, 1'b1);
      chk(hresp, 1'b0);
      for (int a = 0; a <= 32; a += 4) begin
         if (a != 28) rchk(8'(a), 32'hFFFFFFFF, 32'h0);
      end
      wr(8'h20, 32'hFFFFFFFF);
      rchk(8'h20, 32'hFFFFFFFF, 32'h0);
      // monitor switched off in low power
      lowPowerMode <= 1'b1;
      demand <= 13'h0300;
      cyc(DIRC + 8);
      rchk(`CPM_OFS_STAT, 32'h7F, 32'h0);
      chk(dischargeDir, 1'b0);
      demand <= 13'h0;
      cyc(2);
      lowPowerMode <= 1'b0;
      // gain field while measuring, automatic gain otherwise
      for (int g = 0; g < 4; g++) begin
         wr(`CPM_OFS_CTRL, 32'(g));
         rchk(`CPM_OFS_CTRL, 32'hF, 32'(g));
         measPhase <= 1'b1;
         cyc(3);
         chk({30'h0, ampGain}, 32'(g));
         measPhase <= 1'b0;
         cyc(3);
         chk({30'h0, ampGain}, 32'h0);
      end
      wr(`CPM_OFS_CTRL, 32'h0);
      conv(14'h1A5C, 14'h0123);
      conv(14'h0010, 14'h0123);
      // direction debounce with a glitch
      demand <= 13'h0002;
      cyc(DIRC - 4);
      demand <= 13'h0;
      cyc(1);
      demand <= 13'h0002;
      cyc(DIRC - 4);
      chk(dischargeDir, 1'b0);
      cyc(10);
      chk(dischargeDir, 1'b1);
      rchk(`CPM_OFS_STAT, 32'h60, 32'h40);
      demand <= 13'h0;
      cyc(DIRC - 4);
      chk(dischargeDir, 1'b1);
      cyc(10);
      chk(dischargeDir, 1'b0);
      demand <= 13'h1FFE;
      cyc(DIRC + 6);
      chk(chargeDir, 1'b1);
      demand <= 13'h0;
      cyc(DIRC + 6);
      chk(chargeDir, 1'b0);
      // every threshold code of the three faults
      wr(`CPM_OFS_MASK, 32'h1F);
      for (int i = 0; i < 8; i++) begin
         wr(`CPM_OFS_THR, thr(3'(i), 3'h7, 3'h7));
         trip(13'(docT[i]), 13'h0001, 5'h09);
      end
      for (int i = 0; i < 8; i++) begin
         wr(`CPM_OFS_THR, thr(3'h7, 3'(i), 3'h7));
         trip(13'(-cocT[i]), 13'h1FFF, 5'h12);
      end
      wr(`CPM_OFS_DDLY, 32'h3FF);
      for (int i = 0; i < 8; i++) begin
         wr(`CPM_OFS_THR, thr(3'h7, 3'h7, 3'(i)));
         trip(13'(scT[i]), 13'h0001, 5'h0C);
      end
      // zero count fires at once on the ms scale too
      wr(`CPM_OFS_DDLY, 32'h400);
      wr(`CPM_OFS_THR, thr(3'h0, 3'h7, 3'h7));
      trip(13'd40, 13'h0001, 5'h09);
      // five microsecond delay, restarted by a dip
      wr(`CPM_OFS_DDLY, 32'h005);
      demand <= 13'h0064;
      cyc(300);
      demand <= 13'h0;
      cyc(5);
      demand <= 13'h0064;
      cyc(370);
      rchk(`CPM_OFS_STAT, 32'h1F, 32'h0);
      cyc(140);
      rchk(`CPM_OFS_STAT, 32'h1F, 32'h09);
      demand <= 13'h0;
      wr(`CPM_OFS_STAT, 32'h1F);
      // host override owns the FETs except on a short
      wr(`CPM_OFS_MASK, 32'h0);
      wr(`CPM_OFS_DDLY, 32'h0);
      wr(`CPM_OFS_CTRL, 32'hC);
      demand <= 13'h0029;
      cyc(6);
      rchk(`CPM_OFS_STAT, 32'h1F, 32'h09);
      chk(fetEnable, 1'b1);
      chk(irq, 1'b0);
      wr(`CPM_OFS_CTRL, 32'h4);
      cyc(3);
      chk(fetEnable, 1'b0);
      demand <= 13'h0;
      wr(`CPM_OFS_STAT, 32'h1F);
      wr(`CPM_OFS_CTRL, 32'hC);
      wr(`CPM_OFS_THR, thr(3'h7, 3'h7, 3'h0));
      demand <= 13'h00A1;
      cyc(6);
      chk(fetEnable, 1'b0);
      rchk(`CPM_OFS_STAT, 32'h1F, 32'h0C);
      close_out();
   end

   // hang guard, far beyond the expected run length
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
endmodule
